/* aod_pkg.sv */
// Purpose: shared constants for the analog output parameter/diagnostic records
// Assumes: 100 MHz module clock, one byte moved per record access
// Notes:   parameter bytes 0..5, diagnostic bytes 0..19
package aod_pkg;
  // access modes on the record link
  typedef enum logic [1:0] {AOD_MODE_REC, AOD_MODE_OBJ, AOD_MODE_SUB} aod_mode_t;
  localparam int          CLK_NS       = 10;
  localparam int          US_NS        = 1000;
  localparam int          US_CYCLES    = US_NS / CLK_NS;
  localparam logic [6:0]  US_LAST      = 7'(US_CYCLES - 1);
  // record set numbers
  localparam logic [7:0]  REC_PARAM    = 8'h00;
  localparam logic [7:0]  REC_DIAG4    = 8'h00;
  localparam logic [7:0]  REC_DIAG     = 8'h01;
  localparam logic [5:0]  REC_FN_HI    = 6'h20;   // 80h..83h
  // object indexes
  localparam logic [15:0] IDX_PARAM    = 16'h3100;
  localparam logic [15:0] IDX_DIAG     = 16'h2F01;
  localparam logic [15:0] IDX_DIAG4    = 16'h2F00;
  localparam logic [15:0] IDX_SUB_DIAG = 16'h5005;
  // subindexes
  localparam logic [7:0]  SUB_P_FIRST  = 8'h01;
  localparam logic [7:0]  SUB_P_LAST   = 8'h06;
  localparam logic [7:0]  SUB_D_FIRST  = 8'h02;
  localparam logic [7:0]  SUB_D_LAST   = 8'h11;
  localparam logic [7:0]  SUB_TS       = 8'h13;
  // byte counts and positions
  localparam logic [7:0]  PARAM_BYTES  = 8'h06;
  localparam logic [7:0]  DIAG_BYTES   = 8'h14;
  localparam logic [7:0]  DIAG4_BYTES  = 8'h04;
  localparam logic [4:0]  DB_INTERNAL  = 5'h03;
  localparam logic [4:0]  DB_TS        = 5'h10;
  localparam logic [2:0]  PB_SHORT     = 3'h1;
  localparam logic [2:0]  PB_FN0       = 3'h2;
  // reset and constant values
  localparam logic [7:0]  SHORT_RST    = 8'h00;
  localparam logic [7:0]  FN_RST       = 8'h10;
  localparam logic [7:0]  FN_STD       = 8'h10;
  localparam logic [7:0]  FN_ALT       = 8'h20;
  localparam logic [7:0]  FN_OFF       = 8'hFF;
  localparam logic [7:0]  MODULE_INFO  = 8'h15;
  localparam logic [7:0]  CHAN_TYPE    = 8'h73;
  localparam logic [7:0]  DIAG_BITS    = 8'h08;
  localparam logic [7:0]  CHAN_COUNT   = 8'h04;
  // field positions
  localparam int          EA_FAIL      = 0;
  localparam int          EA_INT       = 1;
  localparam int          EA_EXT       = 2;
  localparam int          EA_CHAN      = 3;
  localparam int          EA_AUX       = 4;
  localparam int          EA_PARAM     = 7;
  localparam int          ED_OVF       = 3;
  localparam int          ED_COMM      = 4;
  localparam int          CE_PARAM     = 0;
  localparam int          CE_SHORT     = 3;
  // code scaling: 10h 27648 -> 10000 mV, 20h 16384 -> 10000 mV
  localparam logic [15:0] MAX_STD      = 16'h7EFF;
  localparam logic [15:0] MAX_ALT      = 16'h5000;
  localparam logic [15:0] K_STD        = 16'h5C98;  // 10000*2^16/27648
  localparam logic [15:0] K_ALT        = 16'h2710;  // 10000, then >>14
endpackage : aod_pkg

/* aod_if.sv */
// Purpose: record link between bus head and analog output module
// Assumes: one request pulse, fields stable until ack
// Notes:   ack, rdata and err answer one cycle after req
`timescale 1ns/1ps
`default_nettype none
interface aod_if;
  logic                 req;    // request pulse
  logic                 wr;     // 1 write, 0 read
  logic                 diag;   // 1 diagnostic record
  aod_pkg::aod_mode_t   mode;   // addressing mode
  logic [15:0]          index;  // record set number or object index
  logic [7:0]           sub;    // byte offset or object subindex
  logic [7:0]           wdata;  // write byte
  logic                 ack;    // answer pulse
  logic [7:0]           rdata;  // read byte
  logic                 err;    // access refused
  logic [3:0][15:0]     code;   // output codes per channel
  modport device (input req, wr, diag, mode, index, sub, wdata, code,
                  output ack, rdata, err);
  modport host   (output req, wr, diag, mode, index, sub, wdata, code,
                  input ack, rdata, err);
endinterface : aod_if
`default_nettype wire

/* aod_scale.sv */
// Purpose: one output channel: code scaling to millivolts
// Assumes: code is two's complement
// Notes:   outputs registered, zero while deactivated
`timescale 1ns/1ps
`default_nettype none
module aod_scale (
  input  wire logic        clk,      // module clock
  input  wire logic        reset_n,  // async reset
  input  wire logic        ce,       // clock enable
  input  wire logic [7:0]  fn,       // function number
  input  wire logic [15:0] code,     // output code
  output logic      [15:0] mv,       // output level in mV
  output logic             active    // channel running
);
  wire        is_std = (fn == aod_pkg::FN_STD);
  wire        is_alt = (fn == aod_pkg::FN_ALT);
  wire [15:0] max_c  = is_alt ? aod_pkg::MAX_ALT : aod_pkg::MAX_STD;
  // negative gives 0 V, overrange saturates
  wire [15:0] sat    = code[15] ? 16'h0000 : ((code > max_c) ? max_c : code);  // [RULE4] [RULE5] [RULE22]
  wire [31:0] prod   = sat * (is_alt ? aod_pkg::K_ALT : aod_pkg::K_STD);
  wire [15:0] scaled = is_alt ? prod[29:14] : prod[31:16];
  wire        run    = is_std | is_alt;                                // [RULE3]

  // register level and activity
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mv     <= 16'h0000;
      active <= 1'b0;
    end else if (ce) begin
      mv     <= run ? scaled : 16'h0000;
      active <= run;
    end
  end
endmodule : aod_scale
`default_nettype wire

/* aod_device.sv */
// Purpose: parameter and diagnostic records of a 4-channel analog output module
// Assumes: inputs synchronous to clk; head keeps fields stable until ack
// Notes:   no interrupt; head polls the diagnostic record
// Functional notes
// RULE1: short-circuit enable bit per channel, default off
// RULE2: four function bytes, default 10h
// RULE3: function FFh deactivates the channel
// RULE4: 10h: 27648 is 10V, max 7EFFh
// RULE5: 20h: 16384 is 10V, max 5000h
// RULE6: error lights channel LED and diagnostic record
// RULE7: no interrupt, diagnostics only by reading
// RULE8: report parameter errors; shorts only if enabled
// RULE9: parameters at records 00h and 80h-83h
// RULE10: object indexes 3100h-3105h address parameter bytes
// RULE11: subindex 01h-06h under 3100h plus slot
// RULE12: record 01h full, record 00h four bytes
// RULE13: indexes 2F01h full, 2F00h four bytes
// RULE14: diagnostic subindexes under 5005h from 02h
// RULE15: first diagnostic byte error flags
// RULE16: module info byte is 15h
// RULE17: internal byte: buffer overflow, communication error
// RULE18: constant bytes 73h, 08h, 04h
// RULE19: channel group error byte bit per channel
// RULE20: per-channel byte: parameter error, short
// RULE21: microsecond timestamp captured at diagnostic event
// RULE22: codes above overrange saturate
`timescale 1ns/1ps
`default_nettype none
module aod_device (
  input  wire logic        clk,          // module clock
  input  wire logic        reset_n,      // async reset
  input  wire logic        ce,           // clock enable
  aod_if.device            bus,          // record link
  input  wire logic [7:0]  slot_number,  // slot for subindex access
  input  wire logic [3:0]  short_det,    // short detected per channel
  input  wire logic        module_fail,  // module failure
  input  wire logic        aux_missing,  // auxiliary supply missing
  output logic [3:0][15:0] out_mv,       // channel levels in mV
  output logic [3:0]       out_active,   // channel running
  output logic [3:0]       ch_led        // channel error indicator
);
  logic [7:0]       sc_en;               // short detect enables
  logic [3:0][7:0]  fn;                  // function numbers
  logic [7:0]       mod_diag;            // module diagnostic
  logic [7:0]       int_diag;            // internal diagnostic
  logic [7:0]       grp_err;             // channel group errors
  logic [3:0][7:0]  ch_detail;           // per-channel errors
  logic [31:0]      us_count;            // microsecond ticker
  logic [6:0]       us_pre;              // cycle prescaler
  logic [31:0]      stamp;               // timestamp of last event
  logic             pending;             // event not yet read
  logic [7:0]       rd_byte;             // selected read byte
  logic [3:0]       perr;                // parameter error per channel
  logic [3:0]       serr;                // reported short per channel

  // per-channel scaling and error sources
  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_ch
      aod_scale u_scale (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .fn      (fn[n]),
        .code    (bus.code[n]),
        .mv      (out_mv[n]),
        .active  (out_active[n])
      );
      assign perr[n] = (fn[n] != aod_pkg::FN_STD) && (fn[n] != aod_pkg::FN_ALT)
                       && (fn[n] != aod_pkg::FN_OFF);               // [RULE8]
      assign serr[n] = short_det[n] & sc_en[n] & (fn[n] != aod_pkg::FN_OFF)
                       & ~perr[n];                                   // [RULE1] [RULE8]
    end
  endgenerate

  // address decode for every access mode
  wire        m_rec   = (bus.mode == aod_pkg::AOD_MODE_REC);
  wire        m_obj   = (bus.mode == aod_pkg::AOD_MODE_OBJ);
  wire        m_sub   = (bus.mode == aod_pkg::AOD_MODE_SUB);
  wire [7:0]  rec     = bus.index[7:0];
  wire        rec_hi0 = (bus.index[15:8] == 8'h00);
  wire [15:0] obj_off = bus.index - aod_pkg::IDX_PARAM;
  wire [15:0] sub_idx = aod_pkg::IDX_PARAM + {8'h00, slot_number};
  wire [7:0]  sub_p   = bus.sub - aod_pkg::SUB_P_FIRST;
  wire [7:0]  sub_d   = bus.sub - aod_pkg::SUB_D_FIRST;
  wire [7:0]  sub_t   = bus.sub - aod_pkg::SUB_TS;
  wire        p_rec0  = m_rec && rec_hi0 && rec == aod_pkg::REC_PARAM
                        && bus.sub < 8'h02;                          // [RULE9]
  wire        p_recfn = m_rec && rec_hi0 && rec[7:2] == aod_pkg::REC_FN_HI
                        && bus.sub == 8'h00;                         // [RULE9]
  wire        p_obj   = m_obj && obj_off < 16'(aod_pkg::PARAM_BYTES)
                        && bus.sub == 8'h00;                         // [RULE10]
  wire        p_sub   = m_sub && bus.index == sub_idx
                        && bus.sub >= aod_pkg::SUB_P_FIRST
                        && bus.sub <= aod_pkg::SUB_P_LAST;            // [RULE11]
  wire        p_hit   = !bus.diag && (p_rec0 || p_recfn || p_obj || p_sub);
  wire [2:0]  p_byte  = p_rec0  ? bus.sub[2:0] :
                        p_recfn ? aod_pkg::PB_FN0 + {1'b0, rec[1:0]} :
                        p_obj   ? obj_off[2:0] : sub_p[2:0];
  wire        d_full  = (m_rec && rec_hi0 && rec == aod_pkg::REC_DIAG) ||
                        (m_obj && bus.index == aod_pkg::IDX_DIAG);     // [RULE12] [RULE13]
  wire        d_four  = (m_rec && rec_hi0 && rec == aod_pkg::REC_DIAG4) ||
                        (m_obj && bus.index == aod_pkg::IDX_DIAG4);    // [RULE12] [RULE13]
  wire        d_recok = (d_full && bus.sub < aod_pkg::DIAG_BYTES) ||
                        (d_four && bus.sub < aod_pkg::DIAG4_BYTES);
  wire        d_sub   = m_sub && bus.index == aod_pkg::IDX_SUB_DIAG;
  wire        d_subb  = d_sub && bus.sub >= aod_pkg::SUB_D_FIRST
                        && bus.sub <= aod_pkg::SUB_D_LAST;            // [RULE14]
  wire        d_subt  = d_sub && bus.sub >= aod_pkg::SUB_TS
                        && sub_t < 8'h04;                            // [RULE14]
  wire        d_hit   = bus.diag && (d_recok || d_subb || d_subt);
  wire [4:0]  d_byte  = d_subt ? aod_pkg::DB_TS + sub_t[4:0] :
                        d_subb ? sub_d[4:0] : bus.sub[4:0];
  // diagnostic record is read-only, writes are refused
  wire        acc_ok  = p_hit || (d_hit && !bus.wr);                 // [RULE7]
  wire        take    = ce && bus.req;
  wire        wr_p    = take && acc_ok && bus.wr;
  wire        rd_d    = take && acc_ok && !bus.wr && bus.diag;

  // live diagnostic state
  wire [3:0]      chan_e   = perr | serr;
  wire [7:0]      next_grp_err  = {4'h0, chan_e};                    // [RULE19]
  wire            next_comm     = (take && !acc_ok) ||
                  (int_diag[aod_pkg::ED_COMM] && !(rd_d && d_byte == aod_pkg::DB_INTERNAL));
  wire            ev_new;
  wire            next_ovf      = (ev_new && pending) ||
                  (int_diag[aod_pkg::ED_OVF] && !(rd_d && d_byte == aod_pkg::DB_INTERNAL));
  wire [7:0]      next_int_diag = {3'h0, next_comm, next_ovf, 3'h0};  // [RULE17]
  logic [7:0]     next_mod_diag;
  always_comb begin
    next_mod_diag = 8'h00;
    next_mod_diag[aod_pkg::EA_FAIL]  = module_fail;                  // [RULE15]
    next_mod_diag[aod_pkg::EA_INT]   = |next_int_diag;
    next_mod_diag[aod_pkg::EA_EXT]   = |serr;
    next_mod_diag[aod_pkg::EA_CHAN]  = |chan_e;
    next_mod_diag[aod_pkg::EA_AUX]   = aux_missing;
    next_mod_diag[aod_pkg::EA_PARAM] = |perr;
  end
  // a newly raised error flag is a diagnostic event
  assign ev_new = |((next_mod_diag & ~mod_diag) | (next_grp_err & ~grp_err)
                    | {4'h0, serr & ~{ch_detail[3][3], ch_detail[2][3],
                                      ch_detail[1][3], ch_detail[0][3]}});

  // read byte selection
  always_comb begin
    rd_byte = 8'h00;
    if (!bus.diag) begin
      case (p_byte)
        aod_pkg::PB_SHORT: rd_byte = sc_en;
        3'h2, 3'h3, 3'h4, 3'h5: rd_byte = fn[p_byte - aod_pkg::PB_FN0];
        default: rd_byte = 8'h00;                                    // reserved byte
      endcase
    end else begin
      case (d_byte)
        5'h00: rd_byte = mod_diag;
        5'h01: rd_byte = aod_pkg::MODULE_INFO;                       // [RULE16]
        5'h03: rd_byte = int_diag;
        5'h04: rd_byte = aod_pkg::CHAN_TYPE;                         // [RULE18]
        5'h05: rd_byte = aod_pkg::DIAG_BITS;                         // [RULE18]
        5'h06: rd_byte = aod_pkg::CHAN_COUNT;                        // [RULE18]
        5'h07: rd_byte = grp_err;
        5'h08, 5'h09, 5'h0A, 5'h0B: rd_byte = ch_detail[d_byte[1:0]];
        5'h10, 5'h11, 5'h12, 5'h13: rd_byte = stamp[d_byte[1:0]*8 +: 8];
        default: rd_byte = 8'h00;                                    // reserved bytes
      endcase
    end
  end

  // parameter bytes written by the head
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sc_en    <= aod_pkg::SHORT_RST;                                // [RULE1]
      fn       <= {4{aod_pkg::FN_RST}};                              // [RULE2]
    end else if (wr_p) begin
      if (p_byte == aod_pkg::PB_SHORT)
        sc_en <= {4'h0, bus.wdata[3:0]};                             // [RULE1]
      else if (p_byte >= aod_pkg::PB_FN0)
        fn[p_byte - aod_pkg::PB_FN0] <= bus.wdata;                   // [RULE2] [RULE3]
    end
  end

  // diagnostic record, LEDs and answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mod_diag  <= 8'h00;
      int_diag  <= 8'h00;
      grp_err   <= 8'h00;
      ch_detail <= '0;
      ch_led    <= 4'h0;
      bus.ack   <= 1'b0;
      bus.err   <= 1'b0;
      bus.rdata <= 8'h00;
    end else if (ce) begin
      mod_diag  <= next_mod_diag;                                    // [RULE15] [RULE6]
      int_diag  <= next_int_diag;                                    // [RULE17]
      grp_err   <= next_grp_err;                                     // [RULE19]
      for (int i = 0; i < 4; i++)
        ch_detail[i] <= {4'h0, serr[i], 2'b00, perr[i]};             // [RULE20] [RULE8]
      ch_led    <= chan_e;                                           // [RULE6]
      bus.ack   <= bus.req;
      bus.err   <= bus.req && !acc_ok;
      bus.rdata <= (bus.req && acc_ok && !bus.wr) ? rd_byte : 8'h00;
    end
  end

  // microsecond ticker and event timestamp
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      us_pre   <= 7'h00;
      us_count <= 32'h0000_0000;
      stamp    <= 32'h0000_0000;
      pending  <= 1'b0;
    end else if (ce) begin
      us_pre   <= (us_pre == aod_pkg::US_LAST) ? 7'h00 : us_pre + 7'h01;
      if (us_pre == aod_pkg::US_LAST)
        us_count <= us_count + 32'h0000_0001;                         // [RULE21] wraps
      if (ev_new)
        stamp <= us_count;                                           // [RULE21]
      pending  <= ev_new || (pending && !(rd_d && d_byte == aod_pkg::DB_TS));
    end
  end
endmodule : aod_device
`default_nettype wire

/* aod_host.sv */
// Purpose: bus head end of the record link
// Assumes: one user command at a time
// Notes:   busy high from command until done
`timescale 1ns/1ps
`default_nettype none
module aod_host (
  input  wire logic        clk,        // module clock
  input  wire logic        reset_n,    // async reset
  input  wire logic        ce,         // clock enable
  aod_if.host              bus,        // record link
  input  wire logic        cmd_valid,  // start access
  input  wire logic        cmd_wr,     // 1 write
  input  wire logic        cmd_diag,   // 1 diagnostic record
  input  wire logic [1:0]  cmd_mode,   // addressing mode
  input  wire logic [15:0] cmd_index,  // record set or object index
  input  wire logic [7:0]  cmd_sub,    // byte offset or subindex
  input  wire logic [7:0]  cmd_wdata,  // write byte
  input  wire logic [3:0][15:0] codes, // channel output codes
  output logic             busy,       // access in flight
  output logic             done,       // access finished pulse
  output logic [7:0]       rdata,      // read byte
  output logic             err         // access refused
);
  typedef enum logic {AOD_IDLE, AOD_WAIT} aod_hstate_t;
  aod_hstate_t state;
  wire start = (state == AOD_IDLE) && cmd_valid;

  // request issue and answer capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= AOD_IDLE;
      bus.req <= 1'b0;
      bus.wr <= 1'b0;
      bus.diag <= 1'b0;
      bus.mode <= aod_pkg::AOD_MODE_REC;
      bus.index <= 16'h0000;
      bus.sub <= 8'h00;
      bus.wdata <= 8'h00;
      bus.code <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      err <= 1'b0;
    end else if (ce) begin
      bus.code <= codes;
      bus.req <= start;
      done <= 1'b0;
      case (state)
        AOD_IDLE: begin
          if (start) begin
            bus.wr <= cmd_wr;
            bus.diag <= cmd_diag;
            bus.mode <= aod_pkg::aod_mode_t'(cmd_mode);   // [RULE9] [RULE10] [RULE11]
            bus.index <= cmd_index;                        // [RULE12] [RULE13] [RULE14]
            bus.sub <= cmd_sub;
            bus.wdata <= cmd_wdata;
            busy <= 1'b1;
            state <= AOD_WAIT;
          end
        end
        AOD_WAIT: begin
          if (bus.ack) begin
            rdata <= bus.rdata;
            err <= bus.err;
            done <= 1'b1;
            busy <= 1'b0;
            state <= AOD_IDLE;
          end
        end
        default: state <= AOD_IDLE;
      endcase
    end
  end
endmodule : aod_host
`default_nettype wire

/* aod_checker.sv */
// Purpose: timing and address checks on the record link
// Assumes: ce held high, so every request is answered on the next edge
// Notes:   watches the interface signals only
`timescale 1ns/1ps
`default_nettype none
module aod_checker (
  input wire logic               clk,      // module clock
  input wire logic               reset_n,  // async reset
  input wire logic               req,      // request pulse
  input wire logic               wr,       // write flag
  input wire logic               diag,     // diagnostic record flag
  input wire aod_pkg::aod_mode_t mode,     // addressing mode
  input wire logic [15:0]        index,    // record or object index
  input wire logic [7:0]         sub,      // offset or subindex
  input wire logic               ack,      // answer pulse
  input wire logic [7:0]         rdata,    // read byte
  input wire logic               err       // refusal flag
);
  // request classes
  wire logic rd_d = req && !wr && diag;  // diagnostic read
  wire logic rd_p = req && !diag;        // parameter access
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // answer timing
  property p_ack_next; req |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no answer after request");
  property p_ack_cause; ack |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  // diagnostic record is read only
  property p_diag_wr; req && wr && diag |=> err && rdata == 8'h00; endproperty
  a_diag_wr: assert property (p_diag_wr) else $error("diag write not refused");
  // short and full diagnostic reads
  property p_rec_short;
    rd_d && mode == aod_pkg::AOD_MODE_REC && index == 16'h0000 |=> err == ($past(sub) > 8'h03);
  endproperty
  a_rec_short: assert property (p_rec_short) else $error("record 00h length wrong");
  property p_rec_full;
    rd_d && mode == aod_pkg::AOD_MODE_REC && index == 16'h0001 |=> err == ($past(sub) > 8'h13);
  endproperty
  a_rec_full: assert property (p_rec_full) else $error("record 01h length wrong");
  property p_obj_short;
    rd_d && mode == aod_pkg::AOD_MODE_OBJ && index == 16'h2F00 |=> err == ($past(sub) > 8'h03);
  endproperty
  a_obj_short: assert property (p_obj_short) else $error("index 2F00h length wrong");
  // constant bytes
  property p_info;
    rd_d && mode == aod_pkg::AOD_MODE_OBJ && index == 16'h2F01 && sub == 8'h01
      |=> rdata == 8'h15 && !err;
  endproperty
  a_info: assert property (p_info) else $error("module info byte wrong");
  property p_const;
    rd_d && mode == aod_pkg::AOD_MODE_SUB && index == 16'h5005 && sub inside {8'h06, 8'h07}
      |=> rdata == ($past(sub) == 8'h06 ? 8'h73 : 8'h08);
  endproperty
  a_const: assert property (p_const) else $error("constant byte wrong");
  // parameter addressing
  property p_par_obj;
    rd_p && mode == aod_pkg::AOD_MODE_OBJ && sub == 8'h00 && index inside {[16'h3100:16'h3105]}
      |=> !err;
  endproperty
  a_par_obj: assert property (p_par_obj) else $error("parameter index refused");
  property p_par_rec;
    rd_p && mode == aod_pkg::AOD_MODE_REC && sub == 8'h00 && index inside {[16'h0080:16'h0083]}
      |=> !err;
  endproperty
  a_par_rec: assert property (p_par_rec) else $error("function record refused");
endmodule : aod_checker
`default_nettype wire

/* aod_tb_top.sv */
// Purpose: self-checking bench with host and device joined on the record link
// Assumes: ce high, slot 2, shorts present on channels 0 and 2
// Notes:   table rows first, then scaling, status and mid-run reset cases
`timescale 1ns/1ps
`default_nettype none
module aod_tb_top;
  typedef struct packed {
    logic        wr;     // write access
    logic        diag;   // diagnostic record
    logic [1:0]  mode;   // addressing mode
    logic [15:0] index;  // record or object index
    logic [7:0]  sub;    // offset or subindex
    logic [7:0]  val;    // write byte or expected read byte
    logic        eerr;   // refusal expected
  } aod_row_t;
  logic             clk         = 1'b0;
  logic             reset_n     = 1'b0;
  logic             cmd_valid   = 1'b0;
  logic             cmd_wr      = 1'b0;
  logic             cmd_diag    = 1'b0;
  logic [1:0]       cmd_mode    = 2'h0;
  logic [15:0]      cmd_index   = 16'h0000;
  logic [7:0]       cmd_sub     = 8'h00;
  logic [7:0]       cmd_wdata   = 8'h00;
  logic [3:0][15:0] codes       = {16'h0000, 16'h0000, 16'h4000, 16'h7FFF};
  logic [3:0]       short_det   = 4'h5;
  logic             module_fail = 1'b0;
  logic             aux_missing = 1'b0;
  logic             busy, done, herr;
  logic [7:0]       hrd;
  logic [3:0][15:0] out_mv;
  logic [3:0]       out_active, ch_led;
  int               error_cnt   = 0;
  int               check_count = 0;
  aod_row_t         rows [22]   = '{
    '{1'b0,1'b0,2'h0,16'h0000,8'h01,8'h00,1'b0}, '{1'b0,1'b0,2'h0,16'h0080,8'h00,8'h10,1'b0},
    '{1'b0,1'b0,2'h1,16'h3105,8'h00,8'h10,1'b0}, '{1'b0,1'b0,2'h2,16'h3102,8'h06,8'h10,1'b0},
    '{1'b1,1'b0,2'h1,16'h3101,8'h00,8'hFF,1'b0}, '{1'b0,1'b0,2'h0,16'h0000,8'h01,8'h0F,1'b0},
    '{1'b1,1'b0,2'h0,16'h0081,8'h00,8'h20,1'b0}, '{1'b0,1'b0,2'h1,16'h3103,8'h00,8'h20,1'b0},
    '{1'b1,1'b0,2'h2,16'h3102,8'h05,8'hFF,1'b0}, '{1'b1,1'b0,2'h0,16'h0083,8'h00,8'h33,1'b0},
    '{1'b0,1'b1,2'h1,16'h2F01,8'h01,8'h15,1'b0}, '{1'b0,1'b1,2'h2,16'h5005,8'h06,8'h73,1'b0},
    '{1'b0,1'b1,2'h2,16'h5005,8'h07,8'h08,1'b0}, '{1'b0,1'b1,2'h2,16'h5005,8'h08,8'h04,1'b0},
    '{1'b0,1'b1,2'h0,16'h0001,8'h07,8'h09,1'b0}, '{1'b0,1'b1,2'h0,16'h0001,8'h08,8'h08,1'b0},
    '{1'b0,1'b1,2'h2,16'h5005,8'h0D,8'h01,1'b0}, '{1'b0,1'b1,2'h2,16'h5005,8'h0C,8'h00,1'b0},
    '{1'b0,1'b1,2'h0,16'h0000,8'h00,8'h8E,1'b0}, '{1'b0,1'b1,2'h0,16'h0000,8'h04,8'h00,1'b1},
    '{1'b0,1'b1,2'h1,16'h2F00,8'h04,8'h00,1'b1}, '{1'b1,1'b1,2'h0,16'h0001,8'h00,8'h55,1'b1}};
  aod_if bus ();
  aod_host aod_host_inst (.clk(clk), .reset_n(reset_n), .ce(1'b1), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_wr(cmd_wr), .cmd_diag(cmd_diag), .cmd_mode(cmd_mode),
    .cmd_index(cmd_index), .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata), .codes(codes),
    .busy(busy), .done(done), .rdata(hrd), .err(herr));
  aod_device aod_device_inst (.clk(clk), .reset_n(reset_n), .ce(1'b1), .bus(bus),
    .slot_number(8'h02), .short_det(short_det), .module_fail(module_fail),
    .aux_missing(aux_missing), .out_mv(out_mv), .out_active(out_active), .ch_led(ch_led));
  aod_checker aod_checker_inst (.clk(clk), .reset_n(reset_n), .req(bus.req), .wr(bus.wr),
    .diag(bus.diag), .mode(bus.mode), .index(bus.index), .sub(bus.sub), .ack(bus.ack),
    .rdata(bus.rdata), .err(bus.err));
  // 100 MHz clock
  always #5 clk = ~clk;
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one access through the host, waits for done
  task automatic acc(input aod_row_t r);
    int n;
    @(posedge clk);
    {cmd_wr, cmd_diag, cmd_mode, cmd_index, cmd_sub} <= {r.wr, r.diag, r.mode, r.index, r.sub};
    cmd_wdata <= r.val;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 8);
    if (n >= 8) error_cnt++;
  endtask : acc
  // verdict
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // watchdog
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      acc(rows[i]);
      check(16'(hrd), rows[i].wr ? 16'h0000 : 16'(rows[i].val));
      check(16'(herr), 16'(rows[i].eerr));
    end
    check(out_mv[0], 16'h2DEF);
    check(out_mv[1], 16'h2710);
    check(16'(out_active), 16'h0003);
    check(16'(ch_led), 16'h0009);
    @(posedge clk);
    module_fail <= 1'b1;
    aux_missing <= 1'b1;
    codes[0] <= 16'h8000;
    acc('{1'b0, 1'b1, 2'h0, 16'h0001, 8'h03, 8'h00, 1'b0});
    check(16'(hrd), 16'h0018);
    acc('{1'b0, 1'b1, 2'h0, 16'h0001, 8'h03, 8'h00, 1'b0});
    check(16'(hrd), 16'h0000);
    acc('{1'b0, 1'b1, 2'h2, 16'h5005, 8'h02, 8'h00, 1'b0});
    check(16'(hrd), 16'h009D);
    check(out_mv[0], 16'h0000);
    // reset in mid-run; failure rises 250 cycles after release, stamping 2 us
    @(posedge clk);
    reset_n     <= 1'b0;
    module_fail <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(16'({busy, ch_led}), 16'h0000);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (250) @(posedge clk);
    module_fail <= 1'b1;
    acc('{1'b0, 1'b0, 2'h0, 16'h0083, 8'h00, 8'h00, 1'b0});
    check(16'(hrd), 16'h0010);
    check(16'(out_active), 16'h000F);
    acc('{1'b0, 1'b1, 2'h2, 16'h5005, 8'h13, 8'h00, 1'b0});
    check(16'(hrd), 16'h0002);
    acc('{1'b0, 1'b1, 2'h0, 16'h0000, 8'h00, 8'h00, 1'b0});
    check(16'(hrd), 16'h0013);
    stop_test();
  end
endmodule : aod_tb_top
`default_nettype wire
